// ---- hw/pec_defs.vh ----
// Constants for the pattern error checker: register map, field positions,
// reset values and memory geometry.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PEC_DEFS_VH
`define PEC_DEFS_VH

// Register byte offsets on the AXI4-Lite bus.
`define PEC_OFS_CTRL      8'h00
`define PEC_OFS_STATUS    8'h04
`define PEC_OFS_PAT_LEN   8'h08
`define PEC_OFS_ROW_LEN   8'h0C
`define PEC_OFS_DATA_LEN  8'h10
`define PEC_OFS_ROWS      8'h14
`define PEC_OFS_BLOCKS    8'h18
`define PEC_OFS_ROUTE_MSK 8'h1C
`define PEC_OFS_SCR_ROWS  8'h20
`define PEC_OFS_EDIT_ADDR 8'h24
`define PEC_OFS_EDIT_DATA 8'h28
`define PEC_OFS_COMMIT    8'h2C
`define PEC_OFS_TOTAL_ERR 8'h30
`define PEC_OFS_ROUTE_CNT 8'h80

// Control register field positions.
`define PEC_CTRL_MODE      0
`define PEC_CTRL_POL       2
`define PEC_CTRL_DESCR     3
`define PEC_CTRL_RESTART   4
`define PEC_CTRL_REGION_EN 5
`define PEC_CTRL_ROUTE_EN  6
`define PEC_CTRL_EXT_EN    7
`define PEC_CTRL_AUX_MASK  8
`define PEC_CTRL_RUN       9
`define PEC_CTRL_ORDER_LO  10
`define PEC_CTRL_ORDER_HI  12
`define PEC_CTRL_GANG_LO   13
`define PEC_CTRL_GANG_HI   14
`define PEC_CTRL_CLEAR     16

// Pattern modes.
`define PEC_MODE_DATA  1'b0
`define PEC_MODE_MIXED 1'b1

// Reset values.
`define PEC_RST_CTRL     32'h0000_0000
`define PEC_RST_PAT_LEN  32'h0000_0020
`define PEC_RST_ROW_LEN  32'h0000_0020
`define PEC_RST_DATA_LEN 32'h0000_0008
`define PEC_RST_ROWS     32'h0000_0004
`define PEC_RST_BLOCKS   32'h0000_0001

// Memory geometry: lower half holds pattern bits, upper half region mask bits.
`define PEC_MEM_AW    9
`define PEC_MEM_DEPTH 512
`define PEC_MEM_LAST  9'h1FF

// Region mask step thresholds, in bits per ganged channel.
`define PEC_STEP_T0 32'h0020_0000
`define PEC_STEP_T1 32'h0040_0000
`define PEC_STEP_T2 32'h0080_0000
`define PEC_STEP_T3 32'h0100_0000
`define PEC_STEP_T4 32'h0200_0000
`define PEC_STEP_T5 32'h0400_0000
`define PEC_STEP_T6 32'h0800_0000

`endif

// ---- hw/pec_pat_mem.v ----
// Pattern memory: one write port and two read ports, read data registered.
// Assumes one clock and that the caller presents read addresses a cycle early.
`timescale 1ns/100ps
module pec_pat_mem (
   // Clock.
   input  wire        clk,
   // Write port.
   input  wire        wr_en,
   input  wire [8:0]  wr_addr,
   input  wire [31:0] wr_data,
   // Read ports.
   input  wire [8:0]  rd_a_addr,
   output reg  [31:0] rd_a_data,
   input  wire [8:0]  rd_b_addr,
   output reg  [31:0] rd_b_data
);
`include "pec_defs.vh"

   // Storage array; contents are undefined until loaded.
   reg [31:0] mem [0:`PEC_MEM_DEPTH-1];

   // Write then registered reads; a read of the word being written sees old data.
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end
endmodule

// ---- hw/pec_checker.v ----
// Receive-side test pattern checker with data and mixed references, masks
// and 32 route error counters, reached over AXI4-Lite.
// Assumes RX_BIT, RX_VALID and EXT_MASK are synchronous to CLOCK.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module pec_checker (
   // Clock and reset.
   input  wire        CLOCK,
   input  wire        RST,
   // AXI4-Lite write channels.
   input  wire [7:0]  AWADDR,
   input  wire        AWVALID,
   output reg         AWREADY,
   input  wire [31:0] WDATA,
   input  wire [3:0]  WSTRB,
   input  wire        WVALID,
   output reg         WREADY,
   output reg  [1:0]  BRESP,
   output reg         BVALID,
   input  wire        BREADY,
   // AXI4-Lite read channels.
   input  wire [7:0]  ARADDR,
   input  wire        ARVALID,
   output reg         ARREADY,
   output reg  [31:0] RDATA,
   output reg  [1:0]  RRESP,
   output reg         RVALID,
   input  wire        RREADY,
   // Received stream and auxiliary mask pin.
   input  wire        RX_BIT,
   input  wire        RX_VALID,
   input  wire        EXT_MASK,
   // Status.
   output reg         LOADING
);
`include "pec_defs.vh"

   // Software registers.
   reg  [31:0] ctrl_reg;          // Mode, polarity and mask enables.
   reg  [31:0] pat_len_reg;       // Pattern length in bits.
   reg  [31:0] row_len_reg;       // Bits per row in mixed mode.
   reg  [31:0] data_len_reg;      // Data bits at the start of each row.
   reg  [31:0] rows_reg;          // Rows per block.
   reg  [31:0] blocks_reg;        // Blocks per pattern.
   reg  [31:0] route_msk_reg;     // One mask bit per route counter.
   reg  [31:0] scr_rows_reg;      // Rows whose data area is scrambled.
   reg  [8:0]  edit_addr_reg;     // Edit memory word pointer.
   reg  [31:0] total_err_reg;     // Accumulated unmasked errors.
   wire [1023:0] route_cnt_flat;  // Route counters, 32 bits each.
   // Bus channel holding state.
   reg         aw_held_reg;
   reg  [7:0]  aw_addr_reg;
   reg         w_held_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   // Loader state.
   reg         copy_run_reg;      // Read side of the edit-to-active copy.
   reg  [8:0]  copy_idx_reg;      // Next edit word to read.
   reg         copy_wr_reg;       // Active write pending this cycle.
   reg  [8:0]  copy_wa_reg;       // Active write address.
   // Stream position state and next values.
   reg  [31:0] data_ptr_reg, data_ptr_next;  // Bit index into pattern memory.
   reg  [31:0] row_bit_reg, row_bit_next;    // Bit position within the row.
   reg  [31:0] row_idx_reg, row_idx_next;    // Row within the block.
   reg  [31:0] blk_idx_reg, blk_idx_next;    // Block within the pattern.
   reg  [30:0] prbs_reg, prbs_next;          // Reference LFSR.
   reg  [6:0]  descr_reg;                    // Self-synchronising descrambler.
   reg  [4:0]  tap_hi, tap_lo;               // Selected LFSR taps.
   reg  [3:0]  step_shift;                   // Region mask step as a shift.
   reg  [3:0]  len_k;
   wire [31:0] len_n;
   wire [31:0] mask_idx_next, mask_idx_cur;
   wire [31:0] act_a_data, act_b_data, edit_a_data;

   // Decoded control fields.
   wire       mode_mixed = ctrl_reg[`PEC_CTRL_MODE];
   wire       pol_inv    = ctrl_reg[`PEC_CTRL_POL];
   wire [2:0] order_sel  = ctrl_reg[`PEC_CTRL_ORDER_HI:`PEC_CTRL_ORDER_LO];
   wire [1:0] gang_log2  = ctrl_reg[`PEC_CTRL_GANG_HI:`PEC_CTRL_GANG_LO];
   wire       do_write   = aw_held_reg && w_held_reg && !BVALID;
   wire [31:0] wmask     = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                            {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire       wr_commit  = do_write && (aw_addr_reg == `PEC_OFS_COMMIT) && !LOADING;
   wire       wr_clear   = do_write && (aw_addr_reg == `PEC_OFS_CTRL)
                           && w_data_reg[`PEC_CTRL_CLEAR] && w_strb_reg[2];

   // Write channel: address and data are taken independently, answer follows both.
   always @(posedge CLOCK) begin
      if (RST) begin
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= 2'b00;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else begin
         AWREADY <= !aw_held_reg && !(AWVALID && AWREADY);
         WREADY <= !w_held_reg && !(WVALID && WREADY);
         if (AWVALID && AWREADY) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_held_reg <= 1'b1;
            w_data_reg <= WDATA;
            w_strb_reg <= WSTRB;
         end
         if (do_write) begin
            // Unmapped offsets and the read-only ones answer with a decode error.
            BVALID <= 1'b1;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            BRESP <= (aw_addr_reg > `PEC_OFS_COMMIT || aw_addr_reg[1:0] != 2'b00 ||
                      aw_addr_reg == `PEC_OFS_STATUS) ? 2'b11 : 2'b00;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // Register stores; the clear bit is a pulse and never stays set.
   always @(posedge CLOCK) begin
      if (RST) begin
         ctrl_reg <= `PEC_RST_CTRL;
         pat_len_reg <= `PEC_RST_PAT_LEN;
         row_len_reg <= `PEC_RST_ROW_LEN;
         data_len_reg <= `PEC_RST_DATA_LEN;
         rows_reg <= `PEC_RST_ROWS;
         blocks_reg <= `PEC_RST_BLOCKS;
         route_msk_reg <= 32'h0000_0000;
         scr_rows_reg <= 32'h0000_0000;
         edit_addr_reg <= 9'h000;
      end else if (do_write) begin
         case (aw_addr_reg)
            `PEC_OFS_CTRL: begin
               ctrl_reg <= ((ctrl_reg & ~wmask) | (w_data_reg & wmask)) & 32'h0000_7FFF;
            end
            `PEC_OFS_PAT_LEN:   pat_len_reg <= (pat_len_reg & ~wmask) | (w_data_reg & wmask);
            `PEC_OFS_ROW_LEN:   row_len_reg <= (row_len_reg & ~wmask) | (w_data_reg & wmask);
            `PEC_OFS_DATA_LEN:  data_len_reg <= (data_len_reg & ~wmask) | (w_data_reg & wmask);
            `PEC_OFS_ROWS:      rows_reg <= (rows_reg & ~wmask) | (w_data_reg & wmask);
            `PEC_OFS_BLOCKS:    blocks_reg <= (blocks_reg & ~wmask) | (w_data_reg & wmask);
            `PEC_OFS_ROUTE_MSK: route_msk_reg <= (route_msk_reg & ~wmask) | (w_data_reg & wmask);
            `PEC_OFS_SCR_ROWS: begin
               // Row 0 data can never be marked scrambled.
               scr_rows_reg <= ((scr_rows_reg & ~wmask) | (w_data_reg & wmask))
                               & 32'hFFFF_FFFE;
            end
            `PEC_OFS_EDIT_ADDR: edit_addr_reg <= w_data_reg[8:0];
            `PEC_OFS_EDIT_DATA: edit_addr_reg <= edit_addr_reg + 9'h001;
            default: begin
               // Other offsets store nothing.
            end
         endcase
      end
   end

   // Read channel: one word answered the cycle after the address is taken.
   always @(posedge CLOCK) begin
      if (RST) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= 2'b00;
      end else begin
         ARREADY <= !RVALID && !(ARVALID && ARREADY);
         if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= 2'b00;
            if (ARADDR[7]) begin
               RDATA <= route_cnt_flat[{ARADDR[6:2], 5'h00} +: 32];
            end else begin
               case (ARADDR)
                  `PEC_OFS_CTRL:      RDATA <= ctrl_reg;
                  `PEC_OFS_STATUS:    RDATA <= {31'h0000_0000, LOADING};
                  `PEC_OFS_PAT_LEN:   RDATA <= pat_len_reg;
                  `PEC_OFS_ROW_LEN:   RDATA <= row_len_reg;
                  `PEC_OFS_DATA_LEN:  RDATA <= data_len_reg;
                  `PEC_OFS_ROWS:      RDATA <= rows_reg;
                  `PEC_OFS_BLOCKS:    RDATA <= blocks_reg;
                  `PEC_OFS_ROUTE_MSK: RDATA <= route_msk_reg;
                  `PEC_OFS_SCR_ROWS:  RDATA <= scr_rows_reg;
                  `PEC_OFS_EDIT_ADDR: RDATA <= {23'h00_0000, edit_addr_reg};
                  `PEC_OFS_TOTAL_ERR: RDATA <= total_err_reg;
                  default: begin
                     RDATA <= 32'h0000_0000;
                     RRESP <= 2'b11;
                  end
               endcase
            end
         end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // Software edits land in the edit memory, so the active reference stays
   // intact until the commit copies the whole edit memory across.
   pec_pat_mem u_edit_mem (
      .clk       (CLOCK),
      .wr_en     (do_write && (aw_addr_reg == `PEC_OFS_EDIT_DATA)),
      .wr_addr   (edit_addr_reg),
      .wr_data   (w_data_reg),
      .rd_a_addr (copy_idx_reg),
      .rd_a_data (edit_a_data),
      .rd_b_addr (9'h000),
      .rd_b_data ()
   );

   // Loader: one word per cycle, LOADING high from commit to the last write.
   always @(posedge CLOCK) begin
      if (RST) begin
         LOADING <= 1'b0;
         copy_run_reg <= 1'b0;
         copy_idx_reg <= 9'h000;
         copy_wr_reg <= 1'b0;
         copy_wa_reg <= 9'h000;
      end else begin
         copy_wr_reg <= copy_run_reg;
         copy_wa_reg <= copy_idx_reg;
         if (wr_commit) begin
            LOADING <= 1'b1;
            copy_run_reg <= 1'b1;
            copy_idx_reg <= 9'h000;
         end else if (copy_run_reg) begin
            copy_idx_reg <= copy_idx_reg + 9'h001;
            if (copy_idx_reg == `PEC_MEM_LAST) begin
               copy_run_reg <= 1'b0;
            end
         end else if (copy_wr_reg && copy_wa_reg == `PEC_MEM_LAST) begin
            LOADING <= 1'b0;
         end
      end
   end

   // Region mask step: shift grows by one per doubling beyond the base range, up to 7 doublings,
   // and ganging multiplies both the ranges and the step.
   assign len_n = pat_len_reg >> gang_log2;
   always @* begin
      if (len_n <= `PEC_STEP_T0) len_k = 4'd0;
      else if (len_n <= `PEC_STEP_T1) len_k = 4'd1;
      else if (len_n <= `PEC_STEP_T2) len_k = 4'd2;
      else if (len_n <= `PEC_STEP_T3) len_k = 4'd3;
      else if (len_n <= `PEC_STEP_T4) len_k = 4'd4;
      else if (len_n <= `PEC_STEP_T5) len_k = 4'd5;
      else if (len_n <= `PEC_STEP_T6) len_k = 4'd6;
      else len_k = 4'd7;
      step_shift = len_k + {2'b00, gang_log2};
   end
   assign mask_idx_next = data_ptr_next >> step_shift;
   assign mask_idx_cur  = data_ptr_reg >> step_shift;

   // Active reference: port A reads pattern words, port B region mask words.
   pec_pat_mem u_act_mem (
      .clk       (CLOCK),
      .wr_en     (copy_wr_reg),
      .wr_addr   (copy_wa_reg),
      .wr_data   (edit_a_data),
      .rd_a_addr ({1'b0, data_ptr_next[12:5]}),
      .rd_a_data (act_a_data),
      .rd_b_addr ({1'b1, mask_idx_next[12:5]}),
      .rd_b_data (act_b_data)
   );

   // PRBS taps for x^n + x^m + 1 at the selected order.
   always @* begin
      case (order_sel)
         3'd0: begin tap_hi = 5'd6;  tap_lo = 5'd5;  end
         3'd1: begin tap_hi = 5'd8;  tap_lo = 5'd4;  end
         3'd2: begin tap_hi = 5'd9;  tap_lo = 5'd6;  end
         3'd3: begin tap_hi = 5'd10; tap_lo = 5'd8;  end
         3'd4: begin tap_hi = 5'd14; tap_lo = 5'd13; end
         3'd5: begin tap_hi = 5'd19; tap_lo = 5'd2;  end
         3'd6: begin tap_hi = 5'd22; tap_lo = 5'd17; end
         default: begin tap_hi = 5'd30; tap_lo = 5'd27; end
      endcase
   end

   // Stream bookkeeping and error decision for the current bit.
   wire take     = RX_VALID && ctrl_reg[`PEC_CTRL_RUN] && !LOADING;
   wire in_data  = !mode_mixed || (row_bit_reg < data_len_reg);
   wire row_end  = (row_bit_reg + 32'd1 >= row_len_reg);
   wire blk_end  = row_end && (row_idx_reg + 32'd1 >= rows_reg);
   wire pat_end  = blk_end && (blk_idx_reg + 32'd1 >= blocks_reg);
   wire prbs_bit = prbs_reg[tap_hi] ^ pol_inv;
   wire ref_bit  = in_data ? act_a_data[data_ptr_reg[4:0]] : prbs_bit;
   wire rx_lvl   = RX_BIT ^ pol_inv;
   wire scr_here = ctrl_reg[`PEC_CTRL_DESCR] && mode_mixed && in_data
                   && scr_rows_reg[row_idx_reg[4:0]] && (row_idx_reg < 32'd32);
   wire rx_eff   = scr_here ? (rx_lvl ^ descr_reg[6] ^ descr_reg[5]) : rx_lvl;
   wire err      = rx_eff ^ ref_bit;
   wire [4:0] route = data_ptr_reg[4:0] + row_bit_reg[4:0];
   wire reg_sup  = ctrl_reg[`PEC_CTRL_REGION_EN] && !mode_mixed
                   && act_b_data[mask_idx_cur[4:0]];
   wire rte_sup  = ctrl_reg[`PEC_CTRL_ROUTE_EN] && route_msk_reg[route];
   wire pin_sup  = ctrl_reg[`PEC_CTRL_EXT_EN] && ctrl_reg[`PEC_CTRL_AUX_MASK]
                   && EXT_MASK;
   wire count    = take && err && !(reg_sup || rte_sup || pin_sup);

   // Next-position logic; mixed mode walks rows and blocks, data mode walks bits.
   always @* begin
      data_ptr_next = data_ptr_reg;
      row_bit_next = row_bit_reg;
      row_idx_next = row_idx_reg;
      blk_idx_next = blk_idx_reg;
      prbs_next = prbs_reg;
      if (LOADING || wr_clear) begin
         data_ptr_next = 32'd0;
         row_bit_next = 32'd0;
         row_idx_next = 32'd0;
         blk_idx_next = 32'd0;
         prbs_next = 31'h7FFF_FFFF;
      end else if (take) begin
         if (in_data) begin
            data_ptr_next = (data_ptr_reg + 32'd1 >= pat_len_reg) ? 32'd0 : data_ptr_reg + 32'd1;
         end else begin
            prbs_next = {prbs_reg[29:0], prbs_reg[tap_hi] ^ prbs_reg[tap_lo]};
         end
         if (mode_mixed) begin
            row_bit_next = row_end ? 32'd0 : row_bit_reg + 32'd1;
            if (row_end) begin
               row_idx_next = blk_end ? 32'd0 : row_idx_reg + 32'd1;
            end
            if (blk_end) begin
               blk_idx_next = pat_end ? 32'd0 : blk_idx_reg + 32'd1;
               if (ctrl_reg[`PEC_CTRL_RESTART]) begin
                  prbs_next = 31'h7FFF_FFFF;
               end
               // Otherwise the LFSR simply keeps running into the next block.
            end
            if (pat_end) begin
               data_ptr_next = 32'd0;
            end
         end
      end
   end

   // Position and descrambler registers.
   always @(posedge CLOCK) begin
      if (RST) begin
         data_ptr_reg <= 32'd0;
         row_bit_reg <= 32'd0;
         row_idx_reg <= 32'd0;
         blk_idx_reg <= 32'd0;
         prbs_reg <= 31'h7FFF_FFFF;
         descr_reg <= 7'h00;
      end else begin
         data_ptr_reg <= data_ptr_next;
         row_bit_reg <= row_bit_next;
         row_idx_reg <= row_idx_next;
         blk_idx_reg <= blk_idx_next;
         prbs_reg <= prbs_next;
         if (take) begin
            descr_reg <= {descr_reg[5:0], rx_lvl};
         end
      end
   end

   // Total of unmasked errors; an error landing with a clear is counted after the clear.
   always @(posedge CLOCK) begin
      if (RST) begin
         total_err_reg <= 32'h0000_0000;
      end else if (count) begin
         total_err_reg <= (wr_clear ? 32'h0000_0000 : total_err_reg) + 32'h0000_0001;
      end else if (wr_clear) begin
         total_err_reg <= 32'h0000_0000;
      end
   end

   // One counter per route; a masked route does not count.
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_route
         reg [31:0] cnt_reg;
         always @(posedge CLOCK) begin
            if (RST) begin
               cnt_reg <= 32'h0000_0000;
            end else if (count && route == gi) begin
               cnt_reg <= (wr_clear ? 32'h0000_0000 : cnt_reg) + 32'h0000_0001;
            end else if (wr_clear) begin
               cnt_reg <= 32'h0000_0000;
            end
         end
         assign route_cnt_flat[gi*32 +: 32] = cnt_reg;
      end
   endgenerate
endmodule

// ---- verif/pec_checker_props.sv ----
// Timing checks on the bus, reset and loader ports of the pattern checker.
// Assumes one clock domain and a bind onto every instance of the checker.
`timescale 1ns/100ps
`include "pec_defs.vh"
module pec_checker_props (
   // Clock and reset.
   input wire        CLOCK,
   input wire        RST,
   // Register bus.
   input wire [7:0]  AWADDR,
   input wire        AWVALID,
   input wire        AWREADY,
   input wire [1:0]  BRESP,
   input wire        BVALID,
   input wire        BREADY,
   input wire        ARVALID,
   input wire        ARREADY,
   input wire [31:0] RDATA,
   input wire [1:0]  RRESP,
   input wire        RVALID,
   input wire        RREADY,
   // Loader status.
   input wire        LOADING
);
   reg [9:0] load_cnt;  // Length of the current load, in cycles.

   // Counting the load keeps long durations out of the assertion unroller.
   always @(posedge CLOCK) begin
      if (RST || !LOADING) load_cnt <= 10'h000;
      else load_cnt <= load_cnt + 10'h001;
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped early");
   a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped early");
   a_r_answer: assert property (ARVALID && ARREADY |=> RVALID)
      else $error("read answer late");
   a_aw_drop: assert property (AWVALID && AWREADY |=> !AWREADY)
      else $error("address ready held after handshake");
   a_bresp_code: assert property (BVALID |-> BRESP == 2'h0 || BRESP == 2'h3)
      else $error("illegal write response");
   a_reset_idle: assert property ($fell(RST) |-> !BVALID && !RVALID && !LOADING)
      else $error("outputs busy after reset");
   a_load_start: assert property (AWVALID && AWREADY && AWADDR == `PEC_OFS_COMMIT && !LOADING
      |-> ##[1:4] LOADING) else $error("commit did not start a load");
   a_load_long: assert property ($fell(LOADING) |-> load_cnt >= 10'd500)
      else $error("load ended too soon");
   a_load_bound: assert property (load_cnt <= 10'd600)
      else $error("load runs too long");

   // Main scenarios: refused write, refused read, completed load.
   cover property (BVALID && BREADY && BRESP == 2'h3);
   cover property (RVALID && RREADY && RRESP == 2'h3);
   cover property ($fell(LOADING));
endmodule

bind pec_checker pec_checker_props pec_checker_props_inst (.CLOCK(CLOCK), .RST(RST),
   .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .BRESP(BRESP), .BVALID(BVALID),
   .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
   .RVALID(RVALID), .RREADY(RREADY), .LOADING(LOADING));

// ---- verif/pec_dut_model.sv ----
// Far-side sender: streams one 32-bit word LSB first, with chosen bits flipped.
// Assumes the bench pulses send for one cycle while busy is low.
`timescale 1ns/100ps
module pec_dut_model (
   // Control from the bench.
   input wire        clk,
   input wire        send,
   input wire [31:0] word,
   input wire [31:0] flip,
   input wire        pol,
   // Line towards the checker.
   output reg        rx_bit = 1'h0,
   output reg        rx_valid = 1'h0,
   output reg        busy = 1'h0
);
   reg [4:0] idx = 5'h00;  // Bit being sent.

   // Outside a frame the line toggles, so a stale level can never look valid.
   always @(posedge clk) begin
      if (busy) begin
         rx_valid <= 1'h1;
         rx_bit <= word[idx] ^ flip[idx] ^ pol;
         idx <= idx + 5'h01;
         busy <= (idx != 5'h1F);
      end else begin
         rx_valid <= 1'h0;
         rx_bit <= ~rx_bit;
         busy <= send;
         idx <= 5'h00;
      end
   end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench: AXI4-Lite tasks, a far-side sender, error count checks.
// Assumes the checker's reset values and a 32-bit data pattern in word 0.
`timescale 1ns/100ps
`include "pec_defs.vh"
module tb;
   reg        clk = 1'h0, rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   reg        arvalid = 1'h0, rready = 1'h0, ext_mask = 1'h0, send = 1'h0, pol = 1'h0;
   reg [7:0]  awaddr = 8'h00, araddr = 8'h00;
   reg [31:0] wdata = 32'h0, flip = 32'h0, val;
   reg [1:0]  resp;
   wire       awready, wready, bvalid, arready, rvalid, loading, rx_bit, rx_valid, busy;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer    mismatches = 0, checks = 0, cyc = 0, n;
   localparam [31:0] PAT = 32'hC3A5_0F96, RUN = 32'h200, POL = 32'h4, RTE = 32'h40;
   localparam [31:0] PIN = 32'h80, AUX = 32'h100, CLR = 32'h1_0000;
`define CHK(nm, e, s) begin checks = checks + 1; if ((s) !== (e)) begin \
   mismatches = mismatches + 1; $display("MISMATCH %s exp %0h seen %0h", nm, e, s); end end

   initial forever #20 clk = ~clk;

   pec_checker pec_checker_inst (.CLOCK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
      .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .RX_BIT(rx_bit), .RX_VALID(rx_valid), .EXT_MASK(ext_mask), .LOADING(loading));
   pec_dut_model pec_dut_model_inst (.clk(clk), .send(send), .word(PAT), .flip(flip),
      .pol(pol), .rx_bit(rx_bit), .rx_valid(rx_valid), .busy(busy));

   // Each channel is released at the edge where its ready is seen.
   task automatic wr(input [7:0] a, input [31:0] d);
      integer k;
      reg done;
      begin
         done = 1'h0;
         @(posedge clk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
         for (k = 0; k < 100 && !done; k = k + 1) begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
               resp = bresp;
               bready <= 1'h0;
               done = 1'h1;
            end
         end
         if (!done) mismatches = mismatches + 1;
      end
   endtask

   task automatic rd(input [7:0] a);
      integer k;
      reg done;
      begin
         done = 1'h0;
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
         for (k = 0; k < 100 && !done; k = k + 1) begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
               val = rdata;
               resp = rresp;
               rready <= 1'h0;
               done = 1'h1;
            end
         end
         if (!done) mismatches = mismatches + 1;
      end
   endtask

   task automatic rc(input string nm, input [7:0] a, input [31:0] e);
      begin
         rd(a);
         `CHK(nm, e, val)
      end
   endtask

   // Clear, configure, send one word and compare the accumulated total.
   task automatic sc(input [31:0] ctrl, input [31:0] f, input p, input x, input [31:0] e);
      begin
         wr(`PEC_OFS_CTRL, ctrl | CLR);
         flip <= f;
         pol <= p;
         ext_mask <= x;
         @(posedge clk);
         send <= 1'h1;
         @(posedge clk);
         send <= 1'h0;
         for (n = 0; n < 100 && (n < 2 || busy); n = n + 1) @(posedge clk);
         rc("total", `PEC_OFS_TOTAL_ERR, e);
      end
   endtask

   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks, mismatches);
         if (mismatches == 0 && checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask

   // A hang counts as a mismatch and ends the run.
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         summarize;
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      rc("row_len", `PEC_OFS_ROW_LEN, `PEC_RST_ROW_LEN);
      rc("data_len", `PEC_OFS_DATA_LEN, `PEC_RST_DATA_LEN);
      rc("rows", `PEC_OFS_ROWS, `PEC_RST_ROWS);
      rc("blocks", `PEC_OFS_BLOCKS, `PEC_RST_BLOCKS);
      rd(8'h40);
      `CHK("unmapped", 2'h3, resp)
      wr(`PEC_OFS_TOTAL_ERR, 32'h1);
      `CHK("read_only", 2'h3, resp)
      wr(`PEC_OFS_EDIT_ADDR, 32'h0);
      wr(`PEC_OFS_EDIT_DATA, PAT);
      wr(`PEC_OFS_COMMIT, 32'h1);
      `CHK("loading", 1'h1, loading)
      rd(`PEC_OFS_STATUS);
      `CHK("status", 1'h1, val[0])
      sc(RUN, 32'hFFFF_FFFF, 1'h0, 1'h0, 32'h0);
      for (n = 0; n < 2000 && loading; n = n + 1) @(posedge clk);
      `CHK("load_done", 1'h0, loading)
      wr(`PEC_OFS_ROUTE_MSK, 32'h8);
      sc(RUN, 32'h28, 1'h0, 1'h0, 32'h2);
      rc("route5", 8'h94, 32'h1);
      rc("route4", 8'h90, 32'h0);
      sc(RUN | POL, 32'h1, 1'h1, 1'h0, 32'h1);
      sc(RUN, 32'h0, 1'h1, 1'h0, 32'h20);
      sc(RUN | RTE, 32'h28, 1'h0, 1'h0, 32'h1);
      sc(RUN | PIN, 32'h28, 1'h0, 1'h1, 32'h2);
      sc(RUN | AUX, 32'h28, 1'h0, 1'h1, 32'h2);
      sc(RUN | PIN | AUX, 32'h28, 1'h0, 1'h1, 32'h0);
      sc(RUN | RTE | PIN | AUX, 32'h28, 1'h0, 1'h0, 32'h1);
      sc(32'h0, 32'h28, 1'h0, 1'h0, 32'h0);
      wr(`PEC_OFS_SCR_ROWS, 32'hFFFF_FFFF);
      rc("scr_rows", `PEC_OFS_SCR_ROWS, 32'hFFFF_FFFE);
      wr(`PEC_OFS_EDIT_ADDR, 32'h100);
      wr(`PEC_OFS_EDIT_DATA, 32'h8);
      wr(`PEC_OFS_COMMIT, 32'h1);
      for (n = 0; n < 2000 && loading; n = n + 1) @(posedge clk);
      sc(RUN | 32'h20, 32'h28, 1'h0, 1'h0, 32'h1);
      wr(`PEC_OFS_DATA_LEN, 32'h20);
      sc(RUN | 32'h21, 32'h28, 1'h0, 1'h0, 32'h2);
      sc(RUN | 32'h9, 32'h28, 1'h0, 1'h0, 32'h2);
      summarize;
   end
endmodule
